// file: hdl/emrd_pkg.sv
// package for the external memory read strobe and upper data pin block
// assumes one system clock domain and plain control ports, no bus
package emrd_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int EMRD_DATA_W = 16;   // full external data bus
    localparam int EMRD_UPPER_W = 9;   // upper pins, port f pins 0..8
    localparam int EMRD_UPPER_LSB = 7; // first bus bit shared with port f
    localparam int EMRD_ADDR_W = 24;   // external address bus
    localparam int EMRD_CS_W = 4;      // chip select lines

    // reset values
    localparam logic [EMRD_UPPER_W-1:0] EMRD_GPIO_SEL_RST = 9'h000;
    localparam logic [EMRD_DATA_W-1:0] EMRD_DATA_RST = 16'h0000;
    localparam logic [EMRD_ADDR_W-1:0] EMRD_ADDR_RST = 24'h000000;
    localparam logic [EMRD_CS_W-1:0] EMRD_CS_IDLE = 4'hF;

    // read sequencer states
    typedef enum logic [1:0]
    {
        EMRD_IDLE = 2'b00,
        EMRD_STROBE = 2'b01,
        EMRD_DONE = 2'b10
    } emrd_state_t;

    // qualification carried with a read cycle
    typedef struct packed
    {
        logic [EMRD_ADDR_W-1:0] addr;
        logic prog_sel;             // program space select request
        logic data_sel;             // data space select request
        logic [EMRD_CS_W-1:0] cs;   // chip select request, high active
    } emrd_req_t;

    // per-pin drive of one port f pin group
    typedef struct packed
    {
        logic [EMRD_UPPER_W-1:0] o;
        logic [EMRD_UPPER_W-1:0] oe;
        logic [EMRD_UPPER_W-1:0] pu;
    } emrd_pins_t;
endpackage : emrd_pkg

// file: hdl/emrd_read_port.sv
// read strobe, qualification outputs and upper data / port f pins
// assumes the external part returns data while the strobe is low
`timescale 1ns/100ps

module emrd_read_port
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // read request from the core, accepted when o_rd_ready is high
    input wire logic i_rd_req,
    input wire emrd_pkg::emrd_req_t i_rd_qual,
    output logic o_rd_ready,
    output logic o_rd_valid,
    output logic [emrd_pkg::EMRD_DATA_W-1:0] o_rd_data,
    // configuration
    input wire logic i_bus_drive_select,
    input wire logic i_ctrl_pullup_disable,
    input wire logic [emrd_pkg::EMRD_UPPER_W-1:0] i_port_f_gpio_sel,
    input wire logic [emrd_pkg::EMRD_UPPER_W-1:0] i_port_f_dir_out,
    input wire logic [emrd_pkg::EMRD_UPPER_W-1:0] i_port_f_out,
    input wire logic [emrd_pkg::EMRD_UPPER_W-1:0] i_port_f_pullup_enable,
    output logic [emrd_pkg::EMRD_UPPER_W-1:0] o_port_f_in,
    // read strobe pin
    output logic o_rd_strobe_n,
    output logic o_rd_strobe_oe,
    output logic o_rd_strobe_pu,
    // qualification pins
    output logic [emrd_pkg::EMRD_ADDR_W-1:0] o_ext_address_bus,
    output logic o_program_space_select_n,
    output logic o_data_space_select_n,
    output logic [emrd_pkg::EMRD_CS_W-1:0] o_chip_select_lines_n,
    output logic o_qual_oe,
    // data bus pins
    input wire logic [emrd_pkg::EMRD_DATA_W-1:0] i_ext_data_bus,
    output logic [emrd_pkg::EMRD_DATA_W-1:0] o_ext_data_bus,
    output logic [emrd_pkg::EMRD_DATA_W-1:0] o_ext_data_bus_oe,
    output logic [emrd_pkg::EMRD_UPPER_W-1:0] o_port_f_pullup
);
    import emrd_pkg::*;

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    emrd_state_t state_q; // read sequencer
    emrd_req_t qual_q; // latched qualification of the cycle
    logic [EMRD_UPPER_W-1:0] gpio_sel_q; // pin function per upper pin
    logic [EMRD_DATA_W-1:0] data_q; // internal read register
    logic valid_q; // one-cycle read-done pulse
    logic in_reset_q; // high until first edge after reset release
    logic [EMRD_UPPER_W-1:0] gpio_in_q; // port f input sample

    // upper data bits of the bus, as a field of the full width
    function automatic logic [EMRD_UPPER_W-1:0] upper_of
    (
        input logic [EMRD_DATA_W-1:0] d
    );
        upper_of = d[EMRD_UPPER_LSB +: EMRD_UPPER_W];
    endfunction

    // ----------------------------------------------------------------
    // read sequencer
    // ----------------------------------------------------------------
    // idle -> strobe (one cycle low) -> done (strobe high, data captured)
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= EMRD_IDLE;
        end
        else
        begin
            case (state_q)
                EMRD_IDLE:
                begin
                    if (i_rd_req)
                    begin
                        state_q <= EMRD_STROBE;
                    end
                end
                EMRD_STROBE:
                begin
                    state_q <= EMRD_DONE;
                end
                EMRD_DONE:
                begin
                    state_q <= EMRD_IDLE;
                end
                default:
                begin
                    state_q <= EMRD_IDLE;
                end
            endcase
        end
    end

    // new requests only taken while idle
    assign o_rd_ready = (state_q == EMRD_IDLE);

    // ----------------------------------------------------------------
    // qualification latch
    // ----------------------------------------------------------------
    // qualification held valid
    // latched at acceptance so the pins cannot move under the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            qual_q <= '{addr: EMRD_ADDR_RST, prog_sel: 1'b0,
                        data_sel: 1'b0, cs: '0};
        end
        else if (i_rd_req && state_q == EMRD_IDLE)
        begin
            qual_q <= i_rd_qual;
        end
    end

    // ----------------------------------------------------------------
    // data capture
    // ----------------------------------------------------------------
    // capture on strobe release
    // the strobe rises at the edge leaving EMRD_STROBE; sample then
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            data_q <= EMRD_DATA_RST;
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= (state_q == EMRD_STROBE);
            if (state_q == EMRD_STROBE)
            begin
                for (int i = 0; i < EMRD_UPPER_W; i++)
                begin
                    if (!gpio_sel_q[i])
                    begin
                        data_q[EMRD_UPPER_LSB+i] <=
                            i_ext_data_bus[EMRD_UPPER_LSB+i];
                    end
                    else
                    begin
                        data_q[EMRD_UPPER_LSB+i] <= 1'b0;
                    end
                end
                data_q[EMRD_UPPER_LSB-1:0] <=
                    i_ext_data_bus[EMRD_UPPER_LSB-1:0];
            end
        end
    end

    assign o_rd_data = data_q;
    assign o_rd_valid = valid_q;

    // ----------------------------------------------------------------
    // pin function select and port f input
    // ----------------------------------------------------------------
    // reset to bus function
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            gpio_sel_q <= EMRD_GPIO_SEL_RST;
            gpio_in_q <= '0;
        end
        else
        begin
            gpio_sel_q <= i_port_f_gpio_sel;
            gpio_in_q <= upper_of(i_ext_data_bus) & gpio_sel_q;
        end
    end

    assign o_port_f_in = gpio_in_q;

    // reset flag, cleared at first edge after release
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            in_reset_q <= 1'b1;
        end
        else
        begin
            in_reset_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    always_comb
    begin
        o_rd_strobe_n = (state_q != EMRD_STROBE);
        o_rd_strobe_oe = (state_q == EMRD_STROBE) || i_bus_drive_select;
        o_rd_strobe_pu = !i_ctrl_pullup_disable;
        if (in_reset_q)
        begin
            o_rd_strobe_oe = 1'b0;
            o_rd_strobe_pu = 1'b1;
        end
        // qualification outputs follow the strobe's drive
        o_ext_address_bus = qual_q.addr;
        o_program_space_select_n = !(qual_q.prog_sel &&
                                     state_q == EMRD_STROBE);
        o_data_space_select_n = !(qual_q.data_sel &&
                                  state_q == EMRD_STROBE);
        o_chip_select_lines_n = (state_q == EMRD_STROBE) ? ~qual_q.cs
                                                         : EMRD_CS_IDLE;
        o_qual_oe = o_rd_strobe_oe;
        // bus input during read
        // bus-function pins never driven here, only port f pins are; the write side owns data drive
        o_ext_data_bus = '0;
        o_ext_data_bus_oe = '0;
        for (int i = 0; i < EMRD_UPPER_W; i++)
        begin
            // gpio pins owned by port f
            if (gpio_sel_q[i] && !in_reset_q)
            begin
                o_ext_data_bus[EMRD_UPPER_LSB+i] = i_port_f_out[i];
                o_ext_data_bus_oe[EMRD_UPPER_LSB+i] = i_port_f_dir_out[i];
            end
        end
        // pull-up bit n for pin n
        o_port_f_pullup = in_reset_q ? '1 : i_port_f_pullup_enable;
    end
endmodule // emrd_read_port

// file: tb/emrd_read_port_asserts.sv
// checker bound to the read port block, watching its ports only
// assumes one clock domain with the low-active asynchronous reset
`timescale 1ns/100ps
module emrd_read_port_asserts
    import emrd_pkg::*;
(
    // clock, reset and read side; grouped to keep the checker short
    input wire logic i_clk_sys, i_rst_b, i_rd_req, o_rd_ready,
    input wire emrd_req_t i_rd_qual,
    input wire logic o_rd_valid, o_rd_strobe_n, o_rd_strobe_oe,
    input wire logic [15:0] o_rd_data, i_ext_data_bus, o_ext_data_bus_oe,
    // configuration and pin controls
    input wire logic i_bus_drive_select, i_ctrl_pullup_disable,
    input wire logic o_rd_strobe_pu, o_qual_oe, o_program_space_select_n,
    input wire logic [8:0] i_port_f_gpio_sel, i_port_f_dir_out,
    input wire logic [8:0] i_port_f_pullup_enable, o_port_f_pullup,
    input wire logic [23:0] o_ext_address_bus,
    input wire logic [3:0] o_chip_select_lines_n
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    logic [15:0] gmask; // upper bus bits handed over to port f
    assign gmask = {i_port_f_gpio_sel, 7'h00};
    // a request meets an idle sequencer
    sequence s_taken;
        i_rd_req && o_rd_ready;
    endsequence
    // one low strobe cycle, then the answer as it closes
    sequence s_strobe_valid;
        !o_rd_strobe_n ##1 (o_rd_strobe_n && o_rd_valid);
    endsequence
    a_strobe_cycle:
        assert property (s_taken |=> s_strobe_valid)
        else $error("read strobe cycle wrong");
    a_data_capture:
        assert property ($rose(o_rd_strobe_n) |->
            o_rd_data == ($past(i_ext_data_bus) & ~gmask))
        else $error("read data not captured");
    a_bus_input:
        assert property (!o_rd_strobe_n && $stable(gmask) |->
            (o_ext_data_bus_oe & ~gmask) == 16'h0000)
        else $error("data pins driven during read");
    a_qual_held:
        assert property (!o_rd_strobe_n |-> o_qual_oe && o_rd_strobe_oe
            && o_ext_address_bus == $past(i_rd_qual.addr)
            && (o_chip_select_lines_n ^ $past(i_rd_qual.cs)) == 4'hF
            && o_program_space_select_n != $past(i_rd_qual.prog_sel))
        else $error("qualification wrong during strobe");
    a_idle_drive:
        assert property ($past(i_rst_b) && o_rd_ready
            && $stable(i_bus_drive_select)
            |-> o_rd_strobe_oe == i_bus_drive_select
            && o_qual_oe == o_rd_strobe_oe)
        else $error("idle drive wrong");
    a_strobe_pullup:
        assert property ($past(i_rst_b) && $stable(i_ctrl_pullup_disable)
            |-> o_rd_strobe_pu != i_ctrl_pullup_disable)
        else $error("strobe pull-up wrong");
    a_port_pullup:
        assert property ($past(i_rst_b) && $stable(i_port_f_pullup_enable)
            |-> (o_port_f_pullup & ~i_port_f_pullup_enable) == 9'h000)
        else $error("port pull-up left on");
    a_gpio_drive:
        assert property ($past(i_rst_b) && $stable(gmask)
            && $stable(i_port_f_dir_out) |->
            o_ext_data_bus_oe == (gmask & {i_port_f_dir_out, 7'h00}))
        else $error("port f drive wrong");
endmodule // emrd_read_port_asserts
bind emrd_read_port emrd_read_port_asserts i_chk (.*);

// file: tb/emrd_mem_model.sv
// behavioural memory answering read cycles on the data pins
// assumes the device strobes it low for a whole clock cycle
`timescale 1ns/100ps
module emrd_mem_model
#(
    parameter int P_LAG = 3 // access time in ns
)
(
    // strobe and address from the device
    input wire logic i_strobe_n,
    input wire logic i_strobe_oe,
    input wire logic [23:0] i_addr,
    // data towards the pins, released when not strobed
    output logic o_drive,
    output logic [15:0] o_data
);
    initial o_data = 16'h5A5A;
    // answer only while the strobe qualifies the address
    always @(i_strobe_n or i_strobe_oe or i_addr)
    begin
        o_drive = i_strobe_oe && !i_strobe_n;
        // a released bus flips, so a stale word can never pass
        o_data <= #P_LAG (o_drive ? ~i_addr[15:0] : ~o_data);
    end
endmodule // emrd_mem_model

// file: tb/emrd_read_port_bench.sv
// self-checking bench: read port block with a memory on the pins
// assumes 40 MHz; inputs change 1 ns after each rising edge
`timescale 1ns/100ps
module emrd_read_port_bench;
    import emrd_pkg::*;
    // ----------------------------------------------------------------
    // pins, named as the ports so the instance connects by name
    // ----------------------------------------------------------------
    logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_rd_req = 1'b0;
    logic i_bus_drive_select = 1'b0, i_ctrl_pullup_disable = 1'b0;
    emrd_req_t i_rd_qual = '0;
    logic [8:0] i_port_f_gpio_sel = 9'h1FF, i_port_f_dir_out = 9'h1FF;
    logic [8:0] i_port_f_out = 9'h000, i_port_f_pullup_enable = 9'h1FF;
    logic o_rd_ready, o_rd_valid, o_rd_strobe_n, o_rd_strobe_oe;
    logic o_rd_strobe_pu, o_program_space_select_n, o_data_space_select_n;
    logic o_qual_oe, m_drv;
    logic [8:0] o_port_f_in, o_port_f_pullup;
    logic [15:0] o_rd_data, i_ext_data_bus, o_ext_data_bus;
    logic [15:0] o_ext_data_bus_oe, m_dat;
    logic [23:0] o_ext_address_bus;
    logic [3:0] o_chip_select_lines_n;
    int failures = 0;
    int n_checks = 0;
    // address, chip selects, program space, port f select, read data
    typedef struct {logic [23:0] a; logic [3:0] c; logic p;
        logic [8:0] g; logic [15:0] e;} emrd_row_t;
    emrd_row_t rows [4] = '{'{24'h000000, 4'h1, 1'b1, 9'h000, 16'hFFFF},
        '{24'hFFFFFF, 4'h8, 1'b0, 9'h000, 16'h0000},
        '{24'h123456, 4'h3, 1'b1, 9'h1FF, 16'h0029},
        '{24'h00A5A5, 4'h0, 1'b0, 9'h0AA, 16'h0A5A}};
    // device pins win, then the memory, then the port f pull-ups
    assign i_ext_data_bus = (o_ext_data_bus_oe & o_ext_data_bus)
        | (~o_ext_data_bus_oe & (m_dat
        | (m_drv ? 16'h0000 : {o_port_f_pullup, 7'h00})));
    always #12.5 i_clk_sys = ~i_clk_sys;
    emrd_read_port i_dut (.*);
    emrd_mem_model i_mem (.i_strobe_n(o_rd_strobe_n),
        .i_strobe_oe(o_rd_strobe_oe), .i_addr(o_ext_address_bus),
        .o_drive(m_drv), .o_data(m_dat));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one read at the earliest spacing the sequencer allows
    task automatic rd(input emrd_row_t r);
        i_rd_qual = '{r.a, r.p, !r.p, r.c};
        i_rd_req = 1'b1;
        tick(1);
        i_rd_req = 1'b0;
        cmp({o_rd_strobe_n, o_program_space_select_n,
            o_data_space_select_n, o_qual_oe}, {1'b0, !r.p, r.p, 1'b1});
        cmp(o_ext_address_bus, r.a);
        cmp(o_chip_select_lines_n ^ r.c, 4'hF);
        tick(1);
        cmp({o_rd_strobe_n, o_rd_valid}, 2'b11);
        cmp(o_rd_data, r.e);
        tick(1);
    endtask
    // cut a hang short well past the 47 cycles needed
    initial
    begin
        #20000;
        failures++;
        give_verdict();
    end
    initial
    begin
        tick(10);
        cmp({o_rd_strobe_n, o_rd_strobe_oe, o_rd_strobe_pu, o_rd_ready,
            o_rd_valid}, 5'b10110);
        cmp(o_ext_data_bus_oe, 16'h0000);
        cmp(o_port_f_pullup, 9'h1FF);
        i_port_f_gpio_sel = 9'h000;
        i_port_f_dir_out = 9'h000;
        i_rst_b = 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++)
        begin
            i_port_f_gpio_sel = rows[i].g;
            i_bus_drive_select = i[0];
            tick(1);
            cmp(o_rd_strobe_oe, i_bus_drive_select);
            rd(rows[i]);
        end
        rd(rows[1]);
        i_port_f_gpio_sel = 9'h1FF;
        i_port_f_dir_out = 9'h00F;
        i_port_f_out = 9'h005;
        tick(2);
        cmp(o_ext_data_bus_oe, 16'h0780);
        cmp(o_ext_data_bus & o_ext_data_bus_oe, 16'h0280);
        cmp(o_port_f_in, 9'h1F5);
        rd('{24'h000F0F, 4'h2, 1'b1, 9'h1FF, 16'h0070});
        i_port_f_pullup_enable = 9'h1FE;
        i_ctrl_pullup_disable = 1'b1;
        tick(2);
        cmp({o_port_f_pullup[0], o_rd_strobe_pu}, 2'b00);
        i_ctrl_pullup_disable = 1'b0;
        tick(2);
        cmp(o_rd_strobe_pu, 1'b1);
        // reset in the middle of a strobe
        i_rd_req = 1'b1;
        tick(1);
        i_rd_req = 1'b0;
        i_rst_b = 1'b0;
        #1;
        cmp({o_rd_strobe_n, o_rd_strobe_oe, o_rd_strobe_pu}, 3'b101);
        i_bus_drive_select = 1'b1;
        tick(2);
        i_rst_b = 1'b1;
        tick(2);
        cmp({o_rd_strobe_oe, o_qual_oe}, 2'b11);
        rd(rows[2]);
        give_verdict();
    end
endmodule // emrd_read_port_bench
